// ==== rtl/rgbr_register_bank.sv ====
// Module: control register bank of a three-channel RGB LED driver
// ==========================================================
// Notes on behaviour
// - Offset 0 bit 0 is master enable, read/write; upper bits read zero.
// - Offset 1 bit 0 picks the 25.5mA (0) or 51mA (1) range.
// - Offset 2 bits 2..0 enable channels 2..0; bits 7..3 read zero.
// - Offset 3 holds fade duration 7..4, reserved 3, fade enables 2..0.
// - Enable register resets to 00h; reserved bits read zero, ignore writes.
// - Current-range and channel-enable registers each reset to 00h.
// - Every config field loads its default on any reset; the fault flags reset only on rst_i.
// - 33h to sleep command sleeps; CCh to reset command restores defaults.
// - 55h to apply command commits config registers, only while enabled.
// - Flag clear: bit 1 clears thermal flag, bit 0 power-on flag.
// ==========================================================
`timescale 1ns/1ns
`default_nettype none

module rgbr_register_bank
    import rgbr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       thermal_event_i,
    input  wire logic       wake_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_ack_o,
    output logic            device_enable_o,
    output logic            current_range_o,
    output logic      [2:0] channel_enable_o,
    output logic      [3:0] fade_duration_o,
    output logic      [2:0] channel_fade_enable_o,
    output logic      [2:0] channel_exp_enable_o,
    output logic      [7:0] channel0_dot_current_o,
    output logic      [7:0] channel1_dot_current_o,
    output logic      [7:0] channel2_dot_current_o,
    output logic      [7:0] channel0_duty_o,
    output logic      [7:0] channel1_duty_o,
    output logic      [7:0] channel2_duty_o,
    output logic            sleep_o,
    output logic      [1:0] fault_flags_o
);
    import rgbr_pkg::*;

    // ==========================================================
    // Address decode
    // ==========================================================
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    rgbr_mode_t mode;
    rgbr_mode_t next_mode;

    logic [7:0] device_enable;
    logic [7:0] current_range_config;
    logic [7:0] channel_enable_config;
    logic [7:0] fade_config;
    logic [7:0] curve_config;
    logic [7:0] current_range_live;
    logic [7:0] channel_enable_live;
    logic [7:0] fade_live;
    logic [7:0] curve_live;
    logic [7:0] dot_current [3];
    logic [7:0] duty        [3];
    logic       thermal_shutdown_flag;
    logic       power_on_flag;

    wire logic awake      = (mode == MODE_ACTIVE);
    wire logic wr_ok      = reg_wr_i && awake;
    wire logic wr_enable  = wr_ok && hit(reg_addr_i, OFF_DEVICE_ENABLE);
    wire logic wr_range   = wr_ok && hit(reg_addr_i, OFF_CURRENT_RANGE);
    wire logic wr_chan    = wr_ok && hit(reg_addr_i, OFF_CHANNEL_ENABLE);
    wire logic wr_fade    = wr_ok && hit(reg_addr_i, OFF_FADE_CONFIG);
    wire logic wr_curve   = wr_ok && hit(reg_addr_i, OFF_CURVE_CONFIG);
    wire logic wr_clear   = wr_ok && hit(reg_addr_i, OFF_FLAG_CLEAR);
    wire logic cmd_sleep  = wr_ok && hit(reg_addr_i, OFF_SLEEP_CMD)
                            && (reg_wdata_i == CMD_SLEEP_CODE);
    wire logic cmd_reset  = wr_ok && hit(reg_addr_i, OFF_SOFT_RESET_CMD)
                            && (reg_wdata_i == CMD_RESET_CODE);
    // Commit is ignored while the master enable is off
    wire logic cmd_apply  = wr_ok && hit(reg_addr_i, OFF_APPLY_CMD)
                            && (reg_wdata_i == CMD_APPLY_CODE)
                            && device_enable[0];
    // Every path back to defaults: port reset, reset command, init mode
    wire logic restore    = rst_i || cmd_reset
                            || (mode == MODE_INIT);
    wire logic en_on      = device_enable[0];
    // Flag clear counts only while the device is enabled
    wire logic clr_therm  = wr_clear && en_on
                            && reg_wdata_i[FLAG_THERMAL_BIT];
    wire logic clr_por    = wr_clear && en_on
                            && reg_wdata_i[FLAG_POWER_ON_BIT];

    // ==========================================================
    // Read data selection
    // ==========================================================
    logic [7:0] read_value;
    always_comb begin
        read_value = 8'h00;
        case (reg_addr_i)
            OFF_DEVICE_ENABLE:   read_value = device_enable;
            OFF_CURRENT_RANGE:   read_value = current_range_config;
            OFF_CHANNEL_ENABLE:  read_value = channel_enable_config;
            OFF_FADE_CONFIG:     read_value = fade_config;
            OFF_CURVE_CONFIG:    read_value = curve_config;
            OFF_CH0_DOT_CURRENT: read_value = dot_current[0];
            OFF_CH1_DOT_CURRENT: read_value = dot_current[1];
            OFF_CH2_DOT_CURRENT: read_value = dot_current[2];
            OFF_CH0_DUTY:        read_value = duty[0];
            OFF_CH1_DUTY:        read_value = duty[1];
            OFF_CH2_DUTY:        read_value = duty[2];
            OFF_FAULT_FLAGS: begin
                read_value[FLAG_THERMAL_BIT]  = thermal_shutdown_flag;
                read_value[FLAG_POWER_ON_BIT] = power_on_flag;
            end
            default:             read_value = 8'h00;
        endcase
    end

    // ==========================================================
    // Mode sequencing
    // ==========================================================
    always_comb begin
        case (mode)
            MODE_INIT:   next_mode = MODE_ACTIVE;
            MODE_ACTIVE: next_mode = cmd_sleep ? MODE_SLEEP
                                               : MODE_ACTIVE;
            // Leaving sleep passes through init, which restores defaults
            MODE_SLEEP:  next_mode = wake_i ? MODE_INIT : MODE_SLEEP;
            default:     next_mode = MODE_INIT;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= MODE_INIT;
        end else begin
            mode <= next_mode;
        end
    end

    // ==========================================================
    // Software-visible configuration, masked so reserved bits stay 0
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (restore) begin
            device_enable         <= REG_RESET_VALUE;
            current_range_config  <= REG_RESET_VALUE;
            channel_enable_config <= REG_RESET_VALUE;
            fade_config           <= REG_RESET_VALUE;
            curve_config          <= REG_RESET_VALUE;
        end else begin
            if (wr_enable) begin
                device_enable <= reg_wdata_i & MASK_DEVICE_ENABLE;
            end
            if (wr_range) begin
                current_range_config <= reg_wdata_i
                                        & MASK_CURRENT_RANGE;
            end
            if (wr_chan) begin
                channel_enable_config <= reg_wdata_i
                                         & MASK_CHANNEL_ENABLE;
            end
            if (wr_fade) begin
                fade_config <= reg_wdata_i & MASK_FADE_CONFIG;
            end
            if (wr_curve) begin
                curve_config <= reg_wdata_i & MASK_CURVE_CONFIG;
            end
        end
    end

    // ==========================================================
    // Committed configuration seen by the engines
    // ==========================================================
    // Config edits do not disturb a running animation until committed
    always_ff @(posedge clk_i) begin
        if (restore) begin
            current_range_live  <= REG_RESET_VALUE;
            channel_enable_live <= REG_RESET_VALUE;
            fade_live           <= REG_RESET_VALUE;
            curve_live          <= REG_RESET_VALUE;
        end else if (cmd_apply) begin
            current_range_live  <= current_range_config;
            channel_enable_live <= channel_enable_config;
            fade_live           <= fade_config;
            curve_live          <= curve_config;
        end
    end

    // ==========================================================
    // Per-channel dot current and duty bytes
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (restore) begin
            for (int i = 0; i < 3; i++) begin
                dot_current[i] <= REG_RESET_VALUE;
                duty[i]        <= REG_RESET_VALUE;
            end
        end else if (wr_ok) begin
            case (reg_addr_i)
                OFF_CH0_DOT_CURRENT: dot_current[0] <= reg_wdata_i;
                OFF_CH1_DOT_CURRENT: dot_current[1] <= reg_wdata_i;
                OFF_CH2_DOT_CURRENT: dot_current[2] <= reg_wdata_i;
                OFF_CH0_DUTY:        duty[0]        <= reg_wdata_i;
                OFF_CH1_DUTY:        duty[1]        <= reg_wdata_i;
                OFF_CH2_DUTY:        duty[2]        <= reg_wdata_i;
                default:             ;
            endcase
        end
    end

    // ==========================================================
    // Fault flags: a setting event beats a clear in the same cycle
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thermal_shutdown_flag <= 1'b0;
            power_on_flag         <= 1'b0;
        end else begin
            if (thermal_event_i) begin
                thermal_shutdown_flag <= 1'b1;
            end else if (clr_therm) begin
                thermal_shutdown_flag <= 1'b0;
            end
            if (mode == MODE_INIT) begin
                power_on_flag <= 1'b1;
            end else if (clr_por) begin
                power_on_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Bus answer and registered outputs
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_ack_o   <= 1'b0;
            reg_rdata_o <= 8'h00;
        end else begin
            reg_ack_o   <= reg_wr_i || reg_rd_i;
            reg_rdata_o <= reg_rd_i ? read_value : 8'h00;
        end
    end

    // Channels go dark while thermal_event_i is high, in sleep, or when disabled
    wire logic drive_ok = en_on && awake && !thermal_event_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            device_enable_o       <= 1'b0;
            current_range_o       <= 1'b0;
            channel_enable_o      <= 3'h0;
            fade_duration_o       <= 4'h0;
            channel_fade_enable_o <= 3'h0;
            channel_exp_enable_o  <= 3'h0;
            sleep_o               <= 1'b0;
            fault_flags_o         <= 2'h0;
        end else begin
            device_enable_o       <= en_on;
            current_range_o       <= current_range_live[0];
            channel_enable_o      <= drive_ok ? channel_enable_live[2:0]
                                              : 3'h0;
            fade_duration_o       <= fade_live[FADE_DURATION_MSB:
                                               FADE_DURATION_LSB];
            channel_fade_enable_o <= fade_live[2:0];
            channel_exp_enable_o  <= curve_live[CURVE_EXP_MSB:
                                                CURVE_EXP_LSB];
            sleep_o               <= (next_mode == MODE_SLEEP);
            fault_flags_o         <= {thermal_shutdown_flag,
                                      power_on_flag};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel0_dot_current_o <= 8'h00;
            channel1_dot_current_o <= 8'h00;
            channel2_dot_current_o <= 8'h00;
            channel0_duty_o        <= 8'h00;
            channel1_duty_o        <= 8'h00;
            channel2_duty_o        <= 8'h00;
        end else begin
            channel0_dot_current_o <= dot_current[0];
            channel1_dot_current_o <= dot_current[1];
            channel2_dot_current_o <= dot_current[2];
            channel0_duty_o        <= duty[0];
            channel1_duty_o        <= duty[1];
            channel2_duty_o        <= duty[2];
        end
    end

endmodule : rgbr_register_bank

`default_nettype wire

// ==== rtl/rgbr_pkg.sv ====
// Package: register map, field layout and reset values of the LED control bank
package rgbr_pkg;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] OFF_DEVICE_ENABLE   = 8'h00;
    localparam logic [7:0] OFF_CURRENT_RANGE   = 8'h01;
    localparam logic [7:0] OFF_CHANNEL_ENABLE  = 8'h02;
    localparam logic [7:0] OFF_FADE_CONFIG     = 8'h03;
    localparam logic [7:0] OFF_CURVE_CONFIG    = 8'h04;
    localparam logic [7:0] OFF_SLEEP_CMD       = 8'h0D;
    localparam logic [7:0] OFF_SOFT_RESET_CMD  = 8'h0E;
    localparam logic [7:0] OFF_APPLY_CMD       = 8'h0F;
    localparam logic [7:0] OFF_FLAG_CLEAR      = 8'h13;
    localparam logic [7:0] OFF_CH0_DOT_CURRENT = 8'h14;
    localparam logic [7:0] OFF_CH1_DOT_CURRENT = 8'h15;
    localparam logic [7:0] OFF_CH2_DOT_CURRENT = 8'h16;
    localparam logic [7:0] OFF_CH0_DUTY        = 8'h18;
    localparam logic [7:0] OFF_CH1_DUTY        = 8'h19;
    localparam logic [7:0] OFF_CH2_DUTY        = 8'h1A;
    localparam logic [7:0] OFF_FAULT_FLAGS     = 8'h40;

    // ==========================================================
    // Writable bits of each configuration register
    // ==========================================================
    localparam logic [7:0] MASK_DEVICE_ENABLE  = 8'h01;
    localparam logic [7:0] MASK_CURRENT_RANGE  = 8'h01;
    localparam logic [7:0] MASK_CHANNEL_ENABLE = 8'h07;
    localparam logic [7:0] MASK_FADE_CONFIG    = 8'hF7;
    localparam logic [7:0] MASK_CURVE_CONFIG   = 8'h70;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int FADE_DURATION_LSB = 4;
    localparam int FADE_DURATION_MSB = 7;
    localparam int CURVE_EXP_LSB     = 4;
    localparam int CURVE_EXP_MSB     = 6;
    localparam int FLAG_THERMAL_BIT  = 1;
    localparam int FLAG_POWER_ON_BIT = 0;

    // ==========================================================
    // Command codes and reset value
    // ==========================================================
    localparam logic [7:0] CMD_SLEEP_CODE  = 8'h33;
    localparam logic [7:0] CMD_RESET_CODE  = 8'hCC;
    localparam logic [7:0] CMD_APPLY_CODE  = 8'h55;
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    // ==========================================================
    // Operating modes
    // ==========================================================
    typedef enum logic [1:0] {
        MODE_INIT   = 2'b00,
        MODE_ACTIVE = 2'b01,
        MODE_SLEEP  = 2'b10
    } rgbr_mode_t;

endpackage : rgbr_pkg

// ==== sim/rgbr_host_model.sv ====
// Host-side model that issues single-byte register accesses
`timescale 1ns/1ns
`default_nettype none
module rgbr_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_ack_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o
);
    // Idle cycles before each access; nonzero models a slow host
    int gap = 0;
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'hA5;
        reg_wdata_o = 8'h5A;
    end
    // ==========================================================
    // One strobe per byte; command codes go out as given
    // ==========================================================
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        repeat (gap) @(negedge clk_i);
        @(negedge clk_i);
        reg_wr_o = wr;
        reg_rd_o = !wr;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge clk_i);
        // Answer stands only in the cycle after the strobe edge
        q = reg_ack_i ? reg_rdata_i : 8'hXX;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        // Released lines show the inverse so stale values cannot match
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
        @(negedge clk_i);
    endtask : access
endmodule : rgbr_host_model
`default_nettype wire

// ==== sim/rgbr_register_bank_chk.sv ====
// Checker: timing and field relations at the register bank ports
`timescale 1ns/1ns
`default_nettype none
module rgbr_register_bank_chk
    import rgbr_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       thermal_event_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg_ack_o,
    input wire logic       device_enable_o,
    input wire logic       current_range_o,
    input wire logic [2:0] channel_enable_o,
    input wire logic [2:0] channel_fade_enable_o,
    input wire logic       sleep_o,
    input wire logic [1:0] fault_flags_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Writes that an awake, settled bank must act on
    // ==========================================================
    sequence live_wr(logic [7:0] a);
        reg_wr_i && reg_addr_i == a && !sleep_o && !$past(sleep_o)
            && !$past(rst_i);
    endsequence
    sequence rd_of(logic [7:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    ack_follows_a: assert property (
        (reg_wr_i || reg_rd_i) |=> reg_ack_o)
        else $error("strobe not answered next cycle");
    ack_cause_a: assert property (
        reg_ack_o |-> $past(reg_wr_i || reg_rd_i))
        else $error("answer without a strobe");
    rdata_quiet_a: assert property (
        !(reg_ack_o && $past(reg_rd_i)) |-> reg_rdata_o == 8'h00)
        else $error("read data outside a read answer");
    enable_reserved_a: assert property (
        rd_of(OFF_DEVICE_ENABLE) |=> reg_rdata_o[7:1] == 7'h00)
        else $error("enable upper bits not zero");
    chan_reserved_a: assert property (
        rd_of(OFF_CHANNEL_ENABLE) |=> reg_rdata_o[7:3] == 5'h00)
        else $error("channel enable upper bits not zero");
    // Register then output flop: pins show a bus write two edges later
    enable_write_a: assert property (
        live_wr(OFF_DEVICE_ENABLE)
        |=> ##1 device_enable_o == $past(reg_wdata_i[0], 2))
        else $error("master enable did not follow write");
    sleep_entry_a: assert property (
        live_wr(OFF_SLEEP_CMD) ##0 reg_wdata_i == CMD_SLEEP_CODE
        |=> sleep_o ##1 channel_enable_o == 3'b000)
        else $error("sleep command not obeyed");
    apply_blocked_a: assert property (
        live_wr(OFF_APPLY_CMD) ##0 (reg_wdata_i == CMD_APPLY_CODE
        && !device_enable_o)
        |=> ($stable(current_range_o) && $stable(channel_fade_enable_o))[*2])
        else $error("apply acted while disabled");
    thermal_set_a: assert property (
        thermal_event_i |=> ##1 fault_flags_o[FLAG_THERMAL_BIT])
        else $error("thermal flag not set");
    thermal_clear_a: assert property (
        live_wr(OFF_FLAG_CLEAR) ##0 (reg_wdata_i[FLAG_THERMAL_BIT]
        && device_enable_o && !thermal_event_i)
        |=> ##1 !fault_flags_o[FLAG_THERMAL_BIT])
        else $error("thermal flag not cleared");
endmodule : rgbr_register_bank_chk
bind rgbr_register_bank rgbr_register_bank_chk rgbr_register_bank_chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .thermal_event_i(thermal_event_i), .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o), .device_enable_o(device_enable_o),
    .current_range_o(current_range_o), .channel_enable_o(channel_enable_o),
    .channel_fade_enable_o(channel_fade_enable_o), .sleep_o(sleep_o),
    .fault_flags_o(fault_flags_o));
`default_nettype wire

// ==== sim/rgbr_register_bank_tb.sv ====
// Self-checking bench for the LED control register bank
`timescale 1ns/1ns
`default_nettype none
module rgbr_register_bank_tb;
    import rgbr_pkg::*;
    logic       clk_i, rst_i, thermal_event_i, wake_i, wr, rd, ack;
    logic       dev_en, range, sleep;
    logic [7:0] addr, wdata, rdata, dc0, dc1, dc2, du0, du1, du2, q;
    logic [2:0] ch_en, fade_en, exp_en;
    logic [3:0] fade_dur;
    logic [1:0] flags;
    int         miscompares = 0;
    int         check_count = 0;
    int         cyc = 0;
    logic [7:0] offs [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h14,
                             8'h15, 8'h16, 8'h18, 8'h19, 8'h1A};
    logic [7:0] msk [11] = '{8'h01, 8'h01, 8'h07, 8'hF7, 8'h70, 8'hFF,
                            8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    rgbr_register_bank rgbr_register_bank_i (.clk_i(clk_i), .rst_i(rst_i),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .thermal_event_i(thermal_event_i), .wake_i(wake_i),
        .reg_rdata_o(rdata), .reg_ack_o(ack), .device_enable_o(dev_en),
        .current_range_o(range), .channel_enable_o(ch_en),
        .fade_duration_o(fade_dur), .channel_fade_enable_o(fade_en),
        .channel_exp_enable_o(exp_en), .channel0_dot_current_o(dc0),
        .channel1_dot_current_o(dc1), .channel2_dot_current_o(dc2),
        .channel0_duty_o(du0), .channel1_duty_o(du1), .channel2_duty_o(du2),
        .sleep_o(sleep), .fault_flags_o(flags));
    rgbr_host_model rgbr_host_model_i (.clk_i(clk_i), .reg_rdata_i(rdata),
        .reg_ack_i(ack), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdata));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ==========================================================
    // Checking and access tasks
    // ==========================================================
    task automatic results;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        rgbr_host_model_i.access(1'b1, a, d, q);
    endtask : wrt
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rgbr_host_model_i.access(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask : rdc
    task automatic do_reset;
        rst_i = 1'b1;
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask : do_reset
    // A hung handshake ends the run as a failure
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        rst_i = 1'b1;
        thermal_event_i = 1'b0;
        wake_i = 1'b0;
        do_reset();
        foreach (offs[i]) rdc(offs[i], 8'h00);
        rdc(OFF_FAULT_FLAGS, 8'h01);
        $display("test reset values done");
        foreach (offs[i]) wrt(offs[i], 8'hFF);
        foreach (offs[i]) rdc(offs[i], msk[i]);
        wrt(8'h05, 8'hFF);
        rdc(8'h05, 8'h00);
        rdc(OFF_DEVICE_ENABLE, 8'h01);
        rdc(OFF_APPLY_CMD, 8'h00);
        $display("test field masks done");
        rgbr_host_model_i.gap = 2;
        wrt(OFF_APPLY_CMD, 8'h56);
        chk({7'h00, range}, 8'h00);
        wrt(OFF_APPLY_CMD, CMD_APPLY_CODE);
        @(negedge clk_i);
        chk({fade_dur, 1'b0, ch_en}, 8'hF7);
        chk({5'h00, fade_en}, 8'h07);
        chk({5'h00, exp_en}, 8'h07);
        chk({7'h00, range}, 8'h01);
        wrt(OFF_CURRENT_RANGE, 8'h00);
        wrt(OFF_DEVICE_ENABLE, 8'h00);
        chk({5'h00, ch_en}, 8'h00);
        chk({7'h00, dev_en}, 8'h00);
        wrt(OFF_APPLY_CMD, CMD_APPLY_CODE);
        @(negedge clk_i);
        chk({7'h00, range}, 8'h01);
        wrt(OFF_DEVICE_ENABLE, 8'h01);
        chk({7'h00, dev_en}, 8'h01);
        wrt(OFF_APPLY_CMD, CMD_APPLY_CODE);
        @(negedge clk_i);
        chk({7'h00, range}, 8'h00);
        $display("test apply done");
        rgbr_host_model_i.gap = 0;
        wrt(OFF_FLAG_CLEAR, 8'h01);
        thermal_event_i = 1'b1;
        @(negedge clk_i);
        thermal_event_i = 1'b0;
        @(negedge clk_i);
        chk({6'h00, flags}, 8'h02);
        wrt(OFF_FLAG_CLEAR, 8'h00);
        chk({6'h00, flags}, 8'h02);
        wrt(OFF_FLAG_CLEAR, 8'h02);
        rdc(OFF_FAULT_FLAGS, 8'h00);
        $display("test flag clear done");
        wrt(OFF_CH0_DOT_CURRENT, 8'h5A);
        wrt(OFF_SOFT_RESET_CMD, 8'h12);
        rdc(OFF_CH0_DOT_CURRENT, 8'h5A);
        chk(dc1 & du0 & du2, 8'hFF);
        wrt(OFF_SOFT_RESET_CMD, CMD_RESET_CODE);
        rdc(OFF_CH0_DOT_CURRENT, 8'h00);
        rdc(OFF_DEVICE_ENABLE, 8'h00);
        chk(dc0 | dc1 | du0 | du2, 8'h00);
        $display("test soft reset done");
        wrt(OFF_DEVICE_ENABLE, 8'h01);
        wrt(OFF_CH1_DUTY, 8'h3C);
        wrt(OFF_SLEEP_CMD, 8'h32);
        chk({7'h00, sleep}, 8'h00);
        wrt(OFF_SLEEP_CMD, CMD_SLEEP_CODE);
        chk({7'h00, sleep}, 8'h01);
        wrt(OFF_CH1_DUTY, 8'hC3);
        chk(du1, 8'h3C);
        wake_i = 1'b1;
        @(negedge clk_i);
        wake_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk({7'h00, sleep}, 8'h00);
        rdc(OFF_FAULT_FLAGS, 8'h01);
        rdc(OFF_CH1_DUTY, 8'h00);
        $display("test sleep done");
        wrt(OFF_CH2_DOT_CURRENT, 8'h81);
        do_reset();
        rdc(OFF_CH2_DOT_CURRENT, 8'h00);
        chk(dc2, 8'h00);
        $display("test second reset done");
        results();
    end
endmodule : rgbr_register_bank_tb
`default_nettype wire
